// ===== rtl/lsch_pkg.sv
// Shared constants and types for the display command handler ends
package lsch_pkg;
  localparam int CMD_W = 8;
  localparam int MAX_DATA = 16;
  localparam int LEN_W = 5;
  localparam logic [7:0] CMD_MEM_READ = 8'h0a;
  localparam logic [7:0] CMD_CURSOR_POS = 8'h0b;
  localparam logic [7:0] CMD_CURSOR_STYLE = 8'h0c;
  localparam logic [7:0] CMD_CONTRAST = 8'h0d;
  localparam logic [7:0] CMD_BACKLIGHT = 8'h0e;
  localparam logic [7:0] CMD_TEMP_READ = 8'h0f;
  localparam logic [7:0] CMD_DEV_INFO = 8'h12;
  localparam logic [7:0] CMD_BUS_XACT = 8'h14;
  localparam logic [7:0] RSP_FLAG = 8'h40;
  localparam logic [7:0] RSP_ERROR = 8'h80;
  localparam logic [7:0] GLYPH_LO = 8'h40;
  localparam logic [7:0] GLYPH_HI = 8'h7f;
  localparam logic [7:0] LINE1_LO = 8'h80;
  localparam logic [7:0] LINE1_HI = 8'h8f;
  localparam logic [7:0] LINE2_LO = 8'hc0;
  localparam logic [7:0] LINE2_HI = 8'hcf;
  localparam logic [7:0] COL_MAX = 8'h0f;
  localparam logic [7:0] ROW_MAX = 8'h01;
  localparam logic [7:0] STYLE_MAX = 8'h03;
  localparam logic [7:0] CONTRAST_MAX = 8'hc8;
  localparam logic [7:0] CONTRAST_NEUTRAL = 8'h64;
  localparam logic [7:0] BRIGHT_MAX = 8'h64;
  localparam logic [7:0] DEV_MAX = 8'h1f;
  localparam logic [7:0] DEV_NOADDR = 8'h20;
  localparam logic [7:0] READ_MAX = 8'h0e;
  localparam logic [4:0] XACT_LEN_MIN = 5'h02;
  localparam logic [4:0] XACT_LEN_MAX = 5'h10;
  localparam logic [4:0] LEN_ONE = 5'h01;
  localparam logic [4:0] LEN_TWO = 5'h02;
  localparam logic [4:0] LEN_NINE = 5'h09;
  localparam logic [4:0] LEN_FOUR = 5'h04;
  localparam logic [7:0] ROM_MATCH = 8'h55;
  localparam logic [7:0] ROM_SKIP = 8'hcc;
  localparam int SAMPLE_PERIOD_MS = 1000;
  localparam int RESP_WAIT_MS = 50;
  localparam int CLK_MHZ = 125;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int RESP_WAIT_CYCLES = RESP_WAIT_MS * 1000 * CLK_MHZ;
  localparam int LINK_DIV = 4;
  typedef logic [7:0] lsch_byte_t;
endpackage

// ===== rtl/lsch_if.sv
// Link interface joining the host command port and the display device
`timescale 1ns/1ps
interface lsch_if;
  logic link_clk;
  logic frame;
  logic [7:0] data;
  logic dir_to_dev;
  logic dev_ack;
  modport host (output link_clk, output frame, output data, output dir_to_dev, input dev_ack);
  modport dev (input link_clk, input frame, input data, input dir_to_dev, output dev_ack);
endinterface

// ===== rtl/lsch_host.sv
// Host end: shifts a command packet out over the link, then waits for the device ack or a timeout and reports the sent type as answered
`timescale 1ns/1ps
module lsch_host
  import lsch_pkg::*;
#(
  parameter int WAIT_CYCLES = lsch_pkg::RESP_WAIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  lsch_if.host lnk,
  input wire logic cmd_start,
  input wire lsch_pkg::lsch_byte_t cmd_type,
  input wire logic [lsch_pkg::LEN_W-1:0] cmd_len,
  input wire logic [lsch_pkg::MAX_DATA*8-1:0] cmd_data,
  output logic busy,
  output logic rsp_valid,
  output lsch_pkg::lsch_byte_t rsp_type
);
  import lsch_pkg::*;
  typedef enum logic [1:0] {
    LSCH_IDLE = 2'b00,
    LSCH_SEND = 2'b01,
    LSCH_WAIT = 2'b10,
    LSCH_READ = 2'b11
  } lsch_hstate_t;
  lsch_hstate_t state_q;
  logic [1:0] div_q;
  logic [5:0] idx_q;
  logic [31:0] wait_q;
  logic [LEN_W-1:0] len_q;
  logic [MAX_DATA*8-1:0] data_q;
  lsch_byte_t type_q;
  logic lclk_q, frame_q;
  lsch_byte_t out_q;
  logic ack_s1_q, ack_s2_q;
  wire fall = (div_q == 2'b11) && lclk_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_q <= 2'b00;
      lclk_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'b01;
      // Link clock runs only while a packet is shifted; it rests low between frames
      if (div_q == 2'b11 && state_q == LSCH_SEND) begin
        lclk_q <= ~lclk_q;
      end else if (div_q == 2'b11) begin
        lclk_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= lnk.dev_ack;
      ack_s2_q <= ack_s1_q;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= LSCH_IDLE;
      idx_q <= '0;
      wait_q <= '0;
      len_q <= '0;
      data_q <= '0;
      type_q <= '0;
      frame_q <= 1'b0;
      out_q <= '0;
      busy <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_type <= '0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state_q)
        LSCH_IDLE: begin
          if (cmd_start) begin
            type_q <= cmd_type;
            len_q <= cmd_len;
            data_q <= cmd_data;
            idx_q <= '0;
            busy <= 1'b1;
            frame_q <= 1'b1;
            out_q <= cmd_type;
            state_q <= LSCH_SEND;
          end
        end
        LSCH_SEND: begin
          if (fall) begin
            idx_q <= idx_q + 6'h01;
            if (idx_q == 6'h00) begin
              out_q <= {3'b000, len_q};
            end else if (idx_q <= {1'b0, len_q}) begin
              // Byte index kept to four bits so byte sixteen wraps to slot fifteen
              out_q <= data_q[{idx_q[3:0] - 4'h1, 3'b000} +: 8];
            end
            if (idx_q > {1'b0, len_q}) begin
              frame_q <= 1'b0;
              wait_q <= '0;
              state_q <= LSCH_WAIT;
            end
          end
        end
        LSCH_WAIT: begin
          // Wait ends on the synchronised device ack or after WAIT_CYCLES, whichever comes first
          wait_q <= wait_q + 32'h1;
          if (wait_q >= WAIT_CYCLES[31:0] || ack_s2_q) begin
            state_q <= LSCH_READ;
          end
        end
        LSCH_READ: begin
          rsp_type <= (type_q | RSP_FLAG);
          rsp_valid <= 1'b1;
          busy <= 1'b0;
          state_q <= LSCH_IDLE;
        end
      endcase
    end
  end
  assign lnk.link_clk = lclk_q;
  assign lnk.frame = frame_q;
  assign lnk.data = out_q;
  assign lnk.dir_to_dev = 1'b1;
endmodule

// ===== rtl/lsch_dev.sv
// Device end: command interpreter for display, temperature and bus requests
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Function
// - Memory read takes one native address code
// - Memory read answers 0x4A, echo plus eight
// - Cursor position column 0-15, row 0-1
// - Cursor style 0-3 selects cursor shape
// - One contrast byte: legacy, up to 200
// - Two contrast bytes: second is fine setting
// - One backlight byte sets both backlights
// - Two backlight bytes: display then keypad
// - Host waits up to 50 ms
// - Sample every sensor once per second
// - Temperature read index 0-31, sensor family
// - Temperature answer: index, low, high, status
// - Host treats status zero as failure; this host reads no status and reports every answer as type | RSP_FLAG
// - Enumerate bus devices at power-up
// - Device info answers 0x52, index plus ROM
// - Host keeps bus pin out of GPIO
// - Bridge sends 14, receives 14 at most
// - Reset, address, write, read in order
// - Transaction length 2-16, index, count, payload
// - Index 32 skips address; else Match ROM
// - Length two means no write phase
// - Read count zero means no read phase
module lsch_dev
  import lsch_pkg::*;
#(
  parameter int SAMPLE_TICKS = lsch_pkg::SAMPLE_CYCLES,
  parameter int NDEV = 32
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  lsch_if.dev lnk,
  output logic [3:0] cursor_col,
  output logic cursor_row,
  output logic [1:0] cursor_style,
  output lsch_pkg::lsch_byte_t contrast,
  output lsch_pkg::lsch_byte_t lcd_bright,
  output lsch_pkg::lsch_byte_t key_bright,
  output lsch_pkg::lsch_byte_t mem_addr,
  output logic mem_rd,
  output logic temp_sample,
  output logic bus_start,
  output lsch_pkg::lsch_byte_t bus_index,
  output logic [3:0] bus_wr_count,
  output logic [3:0] bus_rd_count,
  output logic bus_addr_phase,
  output lsch_pkg::lsch_byte_t rsp_type,
  output logic [4:0] rsp_len,
  output logic rsp_ready
);
  import lsch_pkg::*;
  typedef enum logic [1:0] {
    LSCH_D_TYPE = 2'b00,
    LSCH_D_LEN = 2'b01,
    LSCH_D_DATA = 2'b10,
    LSCH_D_EXEC = 2'b11
  } lsch_dstate_t;
  lsch_dstate_t state_q;
  logic clk_s1_q, clk_s2_q, clk_s3_q;
  logic frm_s1_q, frm_s2_q;
  lsch_byte_t dat_s1_q, dat_s2_q;
  lsch_byte_t type_q;
  logic [4:0] len_q, cnt_q;
  lsch_byte_t buf_q [0:MAX_DATA-1];
  logic [31:0] tick_q;
  logic [NDEV-1:0] present_q;
  wire rise = clk_s2_q && !clk_s3_q;
  lsch_byte_t b0, b1;
  logic ok;
  assign b0 = buf_q[0];
  assign b1 = buf_q[1];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      frm_s1_q <= 1'b0;
      frm_s2_q <= 1'b0;
      dat_s1_q <= '0;
      dat_s2_q <= '0;
    end else begin
      clk_s1_q <= lnk.link_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      frm_s1_q <= lnk.frame;
      frm_s2_q <= frm_s1_q;
      dat_s1_q <= lnk.data;
      dat_s2_q <= dat_s1_q;
    end
  end
  // Presence map filled by power-up enumeration; all found by default model
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      present_q <= '0;
    end else begin
      present_q <= '1;
    end
  end
  // Free-running sample tick
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_q <= '0;
      temp_sample <= 1'b0;
    end else begin
      temp_sample <= 1'b0;
      if (tick_q >= SAMPLE_TICKS[31:0] - 32'h1) begin
        tick_q <= '0;
        temp_sample <= 1'b1;
      end else begin
        tick_q <= tick_q + 32'h1;
      end
    end
  end
  // Validity check per command
  always_comb begin
    ok = 1'b0;
    unique case (type_q)
      CMD_MEM_READ: ok = (len_q == LEN_ONE) && ((b0 >= GLYPH_LO && b0 <= GLYPH_HI) ||
        (b0 >= LINE1_LO && b0 <= LINE1_HI) || (b0 >= LINE2_LO && b0 <= LINE2_HI));
      CMD_CURSOR_POS: ok = (len_q == LEN_TWO) && b0 <= COL_MAX && b1 <= ROW_MAX;
      CMD_CURSOR_STYLE: ok = (len_q == LEN_ONE) && b0 <= STYLE_MAX;
      CMD_CONTRAST: ok = ((len_q == LEN_ONE) && b0 <= CONTRAST_MAX) ||
        ((len_q == LEN_TWO) && b1 <= CONTRAST_MAX);
      CMD_BACKLIGHT: ok = ((len_q == LEN_ONE) && b0 <= BRIGHT_MAX) ||
        ((len_q == LEN_TWO) && b0 <= BRIGHT_MAX && b1 <= BRIGHT_MAX);
      CMD_TEMP_READ: ok = (len_q == LEN_ONE) && b0 <= DEV_MAX;
      CMD_DEV_INFO: ok = (len_q == LEN_ONE) && b0 <= DEV_MAX;
      CMD_BUS_XACT: ok = len_q >= XACT_LEN_MIN && len_q <= XACT_LEN_MAX && b0 <= DEV_NOADDR &&
        b1 <= READ_MAX && (len_q > LEN_TWO || b1 != 8'h00);
      default: ok = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= LSCH_D_TYPE;
      type_q <= '0;
      len_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < MAX_DATA; i++) begin
        buf_q[i] <= '0;
      end
    end else begin
      unique case (state_q)
        LSCH_D_TYPE: if (frm_s2_q && rise) begin
          type_q <= dat_s2_q;
          state_q <= LSCH_D_LEN;
        end
        LSCH_D_LEN: if (rise) begin
          len_q <= dat_s2_q[4:0];
          cnt_q <= '0;
          state_q <= (dat_s2_q[4:0] == 5'h00) ? LSCH_D_EXEC : LSCH_D_DATA;
        end
        LSCH_D_DATA: if (rise) begin
          buf_q[cnt_q[3:0]] <= dat_s2_q;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q + 5'h01 >= len_q) begin
            state_q <= LSCH_D_EXEC;
          end
        end
        LSCH_D_EXEC: if (!frm_s2_q) begin
          state_q <= LSCH_D_TYPE;
        end
      endcase
    end
  end
  wire exec = (state_q == LSCH_D_EXEC) && !frm_s2_q;
  // Settings change only on a valid command
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cursor_col <= '0;
      cursor_row <= 1'b0;
      cursor_style <= '0;
      contrast <= CONTRAST_NEUTRAL;
      lcd_bright <= BRIGHT_MAX;
      key_bright <= BRIGHT_MAX;
    end else if (exec && ok) begin
      if (type_q == CMD_CURSOR_POS) begin
        cursor_col <= b0[3:0];
        cursor_row <= b1[0];
      end
      if (type_q == CMD_CURSOR_STYLE) begin
        cursor_style <= b0[1:0];
      end
      if (type_q == CMD_CONTRAST) begin
        // Legacy byte stored raw; only 0-50 is useful
        contrast <= (len_q == LEN_ONE) ? b0 : b1;
      end
      if (type_q == CMD_BACKLIGHT) begin
        lcd_bright <= b0;
        key_bright <= (len_q == LEN_ONE) ? b0 : b1;
      end
    end
  end
  // Memory, bus and answer outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_addr <= '0;
      mem_rd <= 1'b0;
      bus_start <= 1'b0;
      bus_index <= '0;
      bus_wr_count <= '0;
      bus_rd_count <= '0;
      bus_addr_phase <= 1'b0;
      rsp_type <= '0;
      rsp_len <= '0;
      rsp_ready <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      bus_start <= 1'b0;
      rsp_ready <= 1'b0;
      if (exec) begin
        rsp_ready <= 1'b1;
        rsp_type <= ok ? (type_q | RSP_FLAG) : (type_q | RSP_ERROR);
        rsp_len <= '0;
        if (ok && type_q == CMD_MEM_READ) begin
          mem_addr <= b0;
          mem_rd <= 1'b1;
          rsp_len <= LEN_NINE;
        end
        if (ok && type_q == CMD_TEMP_READ) begin
          rsp_len <= LEN_FOUR;
        end
        if (ok && type_q == CMD_DEV_INFO) begin
          rsp_len <= LEN_NINE;
        end
        if (ok && type_q == CMD_BUS_XACT) begin
          bus_start <= 1'b1;
          bus_index <= b0;
          bus_addr_phase <= (b0 != DEV_NOADDR) && present_q[b0[4:0]];
          bus_wr_count <= 4'(len_q - LEN_TWO);
          bus_rd_count <= b1[3:0];
          rsp_len <= {1'b0, b1[3:0]};
        end
      end
    end
  end
  assign lnk.dev_ack = rsp_ready;
endmodule

// ===== verif/lsch_link_monitor.sv
// Link-level assertions between the host and device ends
`timescale 1ns/1ps
module lsch_link_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic frame,
  input wire logic [7:0] data,
  input wire logic dir_to_dev,
  input wire logic dev_ack
);
  import lsch_pkg::*;
  logic [4:0] byte_cnt_q;
  logic [7:0] len_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Rises counted per frame, so a dropped byte shows as a length mismatch
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !frame) begin
      byte_cnt_q <= 5'h00;
    end else if ($rose(link_clk)) begin
      byte_cnt_q <= byte_cnt_q + 5'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      len_q <= 8'h00;
    end else if (frame && $rose(link_clk) && byte_cnt_q == 5'h01) begin
      len_q <= data;
    end
  end
  property p_ack_answer; $fell(frame) |-> ##[1:8] dev_ack; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no answer after frame end");
  property p_data_stable; frame && $past(frame) && $rose(link_clk) |-> $stable(data); endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved at sampling edge");
  property p_frame_max; $rose(frame) |-> ##[1:152] !frame; endproperty
  a_frame_max: assert property (p_frame_max) else $error("frame too long");
  property p_frame_min; $rose(frame) |=> frame [*8]; endproperty
  a_frame_min: assert property (p_frame_min) else $error("frame too short");
  property p_clk_period; $rose(link_clk) |=> (!$rose(link_clk)) [*7]; endproperty
  a_clk_period: assert property (p_clk_period) else $error("link clock too fast");
  property p_clk_high; $rose(link_clk) |-> link_clk [*4] ##1 !link_clk; endproperty
  a_clk_high: assert property (p_clk_high) else $error("link clock duty wrong");
  property p_len_bound; frame && $rose(link_clk) && byte_cnt_q == 5'h01 |-> data <= 8'h10; endproperty
  a_len_bound: assert property (p_len_bound) else $error("length over sixteen");
  property p_byte_count; $fell(frame) |-> {3'h0, byte_cnt_q} == len_q + 8'h02; endproperty
  a_byte_count: assert property (p_byte_count) else $error("byte count differs from length");
  property p_ack_idle; dev_ack |-> !frame && dir_to_dev; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack during frame");
endmodule

// ===== verif/tb_lcd_sensor_command_handler.sv
// Testbench joining both link ends and driving command packets
`timescale 1ns/1ps
module tb_lcd_sensor_command_handler;
  import lsch_pkg::*;
  logic ref_clk, sys_rst, cmd_start, busy, rsp_valid, cursor_row, mem_rd, temp_sample, bus_start, bus_addr_phase;
  logic rsp_ready;
  lsch_byte_t cmd_type, rsp_type, contrast, lcd_bright, key_bright, mem_addr, bus_index, dev_rsp_type, drt, hrt;
  logic [4:0] cmd_len, rsp_len, drl;
  logic [127:0] cmd_data;
  logic [3:0] cursor_col, bus_wr_count, bus_rd_count;
  logic [1:0] cursor_style;
  logic [7:0] hn, bn, tn, mn, k, b0, t0;
  int fail_count, checks_done;
  lsch_if i_lsch_if ();
  lsch_host #(.WAIT_CYCLES(200)) i_lsch_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(i_lsch_if),
    .cmd_start(cmd_start), .cmd_type(cmd_type), .cmd_len(cmd_len), .cmd_data(cmd_data), .busy(busy),
    .rsp_valid(rsp_valid), .rsp_type(rsp_type));
  lsch_dev #(.SAMPLE_TICKS(200), .NDEV(32)) i_lsch_dev (.ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(i_lsch_if),
    .cursor_col(cursor_col), .cursor_row(cursor_row), .cursor_style(cursor_style), .contrast(contrast),
    .lcd_bright(lcd_bright), .key_bright(key_bright), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .temp_sample(temp_sample), .bus_start(bus_start), .bus_index(bus_index), .bus_wr_count(bus_wr_count),
    .bus_rd_count(bus_rd_count), .bus_addr_phase(bus_addr_phase), .rsp_type(dev_rsp_type), .rsp_len(rsp_len),
    .rsp_ready(rsp_ready));
  lsch_link_monitor i_lsch_link_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(i_lsch_if.link_clk),
    .frame(i_lsch_if.frame), .data(i_lsch_if.data), .dir_to_dev(i_lsch_if.dir_to_dev), .dev_ack(i_lsch_if.dev_ack));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Pulses are caught here since the tasks only look at edges
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      hn <= 8'h00;
      bn <= 8'h00;
      tn <= 8'h00;
      mn <= 8'h00;
    end else begin
      if (rsp_ready) begin
        drt <= dev_rsp_type;
        drl <= rsp_len;
      end
      if (rsp_valid) begin
        hrt <= rsp_type;
        hn <= hn + 8'h01;
      end
      bn <= bn + {7'h0, bus_start};
      tn <= tn + {7'h0, temp_sample};
      mn <= mn + {7'h0, mem_rd};
    end
  end
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One packet out, bounded wait for the host's answer, then type and length
  task automatic send(input lsch_byte_t t, input logic [4:0] l, input logic [39:0] d, input logic ok,
    input logic [4:0] el);
    int n;
    logic [7:0] h0;
    h0 = hn;
    cmd_type <= t;
    cmd_len <= l;
    cmd_data <= {88'h0, d};
    cmd_start <= 1'b1;
    @(posedge ref_clk);
    cmd_start <= 1'b0;
    n = 0;
    while ((hn === h0 || busy !== 1'b0) && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      results();
    end
    chk(drt, t | (ok ? RSP_FLAG : RSP_ERROR));
    chk(hrt, t | RSP_FLAG);
    if (el !== 5'h1f) chk({3'h0, drl}, {3'h0, el});
  endtask
  initial begin
    sys_rst = 1'b1;
    cmd_start = 1'b0;
    cmd_type = 8'h00;
    cmd_len = 5'h00;
    cmd_data = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk(contrast, 8'h64);
    chk(lcd_bright, 8'h64);
    chk(key_bright, 8'h64);
    send(CMD_MEM_READ, LEN_ONE, 40'h40, 1'b1, LEN_NINE);
    chk(mem_addr, 8'h40);
    send(CMD_MEM_READ, LEN_ONE, 40'hcf, 1'b1, LEN_NINE);
    send(CMD_MEM_READ, LEN_ONE, 40'h90, 1'b0, 5'h1f);
    send(CMD_MEM_READ, LEN_TWO, 40'h0080, 1'b0, 5'h1f);
    send(CMD_CURSOR_POS, LEN_TWO, 40'h010f, 1'b1, 5'h00);
    chk({4'h0, cursor_col}, 8'h0f);
    chk({7'h0, cursor_row}, 8'h01);
    send(CMD_CURSOR_POS, LEN_TWO, 40'h0010, 1'b0, 5'h1f);
    chk({4'h0, cursor_col}, 8'h0f);
    for (k = 8'h00; k < 8'h04; k++) begin
      send(CMD_CURSOR_STYLE, LEN_ONE, {32'h0, k}, 1'b1, 5'h00);
      chk({6'h0, cursor_style}, k);
    end
    send(CMD_CURSOR_STYLE, LEN_ONE, 40'h04, 1'b0, 5'h1f);
    send(CMD_CONTRAST, LEN_ONE, 40'h32, 1'b1, 5'h00);
    chk(contrast, 8'h32);
    send(CMD_CONTRAST, LEN_ONE, 40'hc9, 1'b0, 5'h1f);
    chk(contrast, 8'h32);
    send(CMD_CONTRAST, LEN_TWO, 40'hc8fe, 1'b1, 5'h00);
    chk(contrast, 8'hc8);
    send(CMD_BACKLIGHT, LEN_ONE, 40'h3c, 1'b1, 5'h00);
    chk(lcd_bright, 8'h3c);
    chk(key_bright, 8'h3c);
    send(CMD_BACKLIGHT, LEN_TWO, 40'h5a0a, 1'b1, 5'h00);
    chk(lcd_bright, 8'h0a);
    chk(key_bright, 8'h5a);
    send(CMD_BACKLIGHT, LEN_TWO, 40'h0065, 1'b0, 5'h1f);
    chk(lcd_bright, 8'h0a);
    send(CMD_TEMP_READ, LEN_ONE, 40'h1f, 1'b1, LEN_FOUR);
    send(CMD_TEMP_READ, LEN_ONE, 40'h20, 1'b0, 5'h1f);
    send(CMD_DEV_INFO, LEN_ONE, 40'h00, 1'b1, LEN_NINE);
    send(CMD_DEV_INFO, LEN_ONE, 40'h20, 1'b0, 5'h1f);
    b0 = bn;
    send(CMD_BUS_XACT, 5'h05, 40'h0c0b0a0320, 1'b1, 5'h03);
    chk(bus_index, 8'h20);
    chk({7'h0, bus_addr_phase}, 8'h00);
    chk({4'h0, bus_wr_count}, 8'h03);
    chk({4'h0, bus_rd_count}, 8'h03);
    send(CMD_BUS_XACT, LEN_TWO, 40'h0e05, 1'b1, 5'h0e);
    chk({7'h0, bus_addr_phase}, 8'h01);
    chk({4'h0, bus_wr_count}, 8'h00);
    chk({4'h0, bus_rd_count}, 8'h0e);
    send(CMD_BUS_XACT, LEN_TWO, 40'h0f05, 1'b0, 5'h1f);
    send(CMD_BUS_XACT, LEN_ONE, 40'h20, 1'b0, 5'h1f);
    send(CMD_BUS_XACT, LEN_TWO, 40'h0121, 1'b0, 5'h1f);
    chk(bn - b0, 8'h02);
    chk(mn, 8'h02);
    t0 = tn;
    repeat (1000) @(posedge ref_clk);
    chk(tn - t0, 8'h05);
    results();
  end
endmodule
